// ### sim/stac_spi_host.sv
// Purpose: Behavioural serial host in mode 0 that drives the link of the block.
// Assumes: Link clock period of 15 ns; the clock stands low between frames.
// Notes: A frame may be clocked with select held high to prove it is ignored.
`timescale 1ns/1ps

module stac_spi_host
(
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    localparam realtime HALF = 7.5;

    // Idle link: clock low, not selected.
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // Sends n bits MSB first and captures the output on each rising edge.
    task automatic frame(input logic [15:0] bits, input int n, input logic sel,
        output logic [15:0] got);
        got = '0;
        cs_n = !sel;
        #(HALF + 1.3); // Offset keeps link edges clear of core clock edges.
        for (int i = n - 1; i >= 0; i--)
        begin
            din = bits[i];
            #HALF;
            sclk = 1'b1;
            got = {got[14:0], dout};
            #HALF;
            sclk = 1'b0;
        end
        #HALF;
        cs_n = 1'b1;
        // A released input line shows the opposite of its last value.
        din = !din;
        // Select stays high a while, so two frames never meet in one step.
        #HALF;
    endtask : frame

endmodule : stac_spi_host

// ### sim/stac_top_asserts.sv
// Purpose: Concurrent checks on the ports of the serial temperature ADC control block.
// Assumes: All checks run in the core clock domain and sample the link pins there.
// Notes: A small counter measures how long the conversion strobe stays low.
`timescale 1ns/1ps

module stac_top_asserts
#(
    parameter int FCLK_DIV = stac_pkg::FCLK_DIV_CYC,
    parameter int WAKE_EXT = stac_pkg::WAKE_CYC,
    parameter int WAKE_INT = stac_pkg::WAKE_CYC
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic conversion_done_strobe,
    input wire logic [stac_pkg::SAMPLE_BITS-1:0] adc_sample,
    input wire stac_pkg::stac_afe_ctrl_t afe_ctrl
);
    import stac_pkg::*;

    // ------------------------------------------------------------
    // Strobe low-time counter.
    // ------------------------------------------------------------
    localparam int CONV_MAX = WAKE_INT + WAKE_EXT + TEMP_PERIODS * FCLK_DIV + 64;
    logic [CNT_W-1:0] low_cnt_q;

    // Counts core cycles while the strobe is low; the longest legal wait bounds it.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt_q <= '0;
        else if (conversion_done_strobe)
            low_cnt_q <= '0;
        else
            low_cnt_q <= low_cnt_q + 1'b1;
    end

    // ------------------------------------------------------------
    // Properties.
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_launch;
        $fell(conversion_done_strobe);
    endsequence

    sequence s_finish;
        $rose(conversion_done_strobe);
    endsequence

    AST_OE_FOLLOWS_SELECT: assert property (dout_oe == !cs_n)
        else $error("serial output enable does not follow chip select");
    AST_POWER_UP_SHUTDOWN: assert property ($rose(nrst) |->
        afe_ctrl.power_mode_select == PM_SHUTDOWN)
        else $error("power mode after reset is not shutdown");
    AST_STROBE_FALLS_LOW_SCLK: assert property (s_launch |-> !sclk && !cs_n)
        else $error("strobe fell outside a selected falling serial clock");
    AST_STROBE_HOLDS_LOW: assert property (s_launch |=> !conversion_done_strobe [*8])
        else $error("strobe rose too soon after a launch");
    AST_MIN_CONV_LENGTH: assert property (s_finish |->
        low_cnt_q >= VOLT_PERIODS * FCLK_DIV)
        else $error("conversion shorter than the voltage period count");
    AST_MAX_CONV_LENGTH: assert property (!conversion_done_strobe |-> low_cnt_q < CONV_MAX)
        else $error("conversion strobe stuck low");
    // The sample pulse is registered, so the last one rises in the same cycle as the strobe; the check looks one cycle back.
    AST_SAMPLE_IN_CONV: assert property (afe_ctrl.sample_take |-> !$past(conversion_done_strobe))
        else $error("sample taken while no conversion runs");
    AST_TEMP_INTERNAL_REF: assert property (afe_ctrl.temp_enable |-> afe_ctrl.ref_internal)
        else $error("temperature conversion without the internal reference");
    AST_SAMPLE_ONE_CYCLE: assert property (afe_ctrl.sample_take |=> !afe_ctrl.sample_take)
        else $error("sample pulse longer than one cycle");
    AST_DOUT_HOLDS_SCLK_HIGH: assert property (sclk && $past(sclk) && !cs_n &&
        !$past(cs_n) && conversion_done_strobe && $past(conversion_done_strobe)
        |-> $stable(dout_o))
        else $error("serial output changed while serial clock was high");

endmodule : stac_top_asserts

bind stac_top stac_top_asserts #(.FCLK_DIV(FCLK_DIV), .WAKE_EXT(WAKE_EXT),
    .WAKE_INT(WAKE_INT)) u_asserts (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
    .conversion_done_strobe(conversion_done_strobe), .adc_sample(adc_sample),
    .afe_ctrl(afe_ctrl));

// ### sim/testbench.sv
// Purpose: Self-checking bench for the serial temperature ADC control block.
// Assumes: Short converter divider and wake counts; front end modelled here.
// Notes: Each sample pulse raises the sample value by a fixed step after it ends.
`timescale 1ns/1ps

`define CHECK(act, exp) \
    begin \
        n_compared++; \
        if ((act) !== (exp)) \
        begin \
            n_fail++; \
            $display("unexpected at %0t: got %0h expected %0h", $time, act, exp); \
        end \
    end

module testbench;
    import stac_pkg::*;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] conv;
        logic [12:0] samp;
        logic [1:0] kind;
        logic [1:0] pm;
    } stac_row_t;

    localparam int FDIV = 4;
    localparam int WAKE = 2;
    localparam logic [12:0] STEP = 13'h0123;
    localparam stac_row_t ROWS [10] = '{
        '{8'h87, 8'hA0, 13'h0ABC, 2'h0, PM_NORMAL},
        '{8'h82, 8'hAB, 13'h1F00, 2'h0, PM_STANDBY_PLUS},
        '{8'h85, 8'hA7, 13'h0400, 2'h1, PM_STANDBY},
        '{8'h80, 8'hAC, 13'h0010, 2'h1, PM_SHUTDOWN},
        '{8'h00, 8'hAD, 13'h0777, 2'h1, PM_SHUTDOWN},
        '{8'h86, 8'hA5, 13'h0555, 2'h2, PM_NORMAL},
        '{8'h00, 8'hA4, 13'h1234, 2'h0, PM_NORMAL},
        '{8'h00, 8'hA6, 13'h0FFF, 2'h0, PM_NORMAL},
        '{8'h00, 8'hA8, 13'h1000, 2'h0, PM_NORMAL},
        '{8'h00, 8'hA3, 13'h0001, 2'h0, PM_NORMAL}
    };

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [12:0] adc_sample = 13'h0000;
    logic took = 1'b0;
    logic dout_o;
    logic dout_oe;
    logic strobe;
    stac_afe_ctrl_t afe_ctrl;
    wire sclk;
    wire cs_n;
    wire din;
    wire dout_w;
    logic [15:0] got;
    int n_fail = 0;
    int n_compared = 0;

    // The output floats whenever the block releases it.
    assign dout_w = dout_oe ? dout_o : 1'bz;

    always #2.5 ref_clk = ~ref_clk;

    // Front end: the sample moves one cycle after each pulse, never during it.
    always @(negedge ref_clk)
    begin
        if (took)
            adc_sample = adc_sample + STEP;
        took = afe_ctrl.sample_take;
    end

    stac_top #(.FCLK_DIV(FDIV), .WAKE_EXT(WAKE), .WAKE_INT(WAKE)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .dout_oe(dout_oe), .conversion_done_strobe(strobe),
        .adc_sample(adc_sample), .afe_ctrl(afe_ctrl));

    stac_spi_host u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_w));

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_frame(input logic [1:0] kind, input logic [12:0] s);
        if (kind == 2'h0)
            return {s[12], s, 2'b00};
        else if (kind == 2'h1)
            return {2'b00, STEP[11:0], 2'b00};
        return 16'h0000;
    endfunction : exp_frame

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // Waits for the result, then reads sixteen bits and four more.
    task automatic convert_and_read(input logic [1:0] kind, input logic [12:0] s);
        int k;
        logic [15:0] mask;
        mask = (kind == 2'h1) ? 16'h3FFF : 16'hFFFF;
        k = 0;
        `CHECK(strobe, 1'b0)
        while (strobe !== 1'b1 && k < 5000)
        begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 5000)
        begin
            n_fail++;
            finish_test();
        end
        else
        begin
            @(negedge ref_clk);
            u_host.frame(16'h0000, 16, 1'b1, got);
            `CHECK(got & mask, exp_frame(kind, s) & mask)
            u_host.frame(16'h0000, 4, 1'b1, got);
            `CHECK(got[3:0], 4'h0)
        end
    endtask : convert_and_read

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHECK(afe_ctrl.power_mode_select, PM_SHUTDOWN)
        `CHECK(strobe, 1'b1)
        foreach (ROWS[i])
        begin
            @(negedge ref_clk);
            adc_sample = ROWS[i].samp;
            if (ROWS[i].cfg != 8'h00)
                u_host.frame({ROWS[i].cfg, ROWS[i].conv}, 16, 1'b1, got);
            else
                u_host.frame({8'h00, ROWS[i].conv}, 8, 1'b1, got);
            convert_and_read(ROWS[i].kind, ROWS[i].samp);
            `CHECK(afe_ctrl.power_mode_select, ROWS[i].pm)
            `CHECK(afe_ctrl.input_channel_select, ROWS[i].conv[3:0])
        end
        // Clocking with select high mid-conversion must change nothing.
        @(negedge ref_clk);
        adc_sample = 13'h0321;
        u_host.frame(16'h00A0, 8, 1'b1, got);
        u_host.frame(16'h0081, 8, 1'b0, got);
        convert_and_read(2'h0, 13'h0321);
        `CHECK(afe_ctrl.power_mode_select, PM_NORMAL)
        // A byte of neither pattern is dropped.
        u_host.frame(16'h00C1, 8, 1'b1, got);
        repeat (50) @(negedge ref_clk);
        `CHECK(strobe, 1'b1)
        `CHECK(afe_ctrl.power_mode_select, PM_NORMAL)
        // Leading zeros before the start bit are skipped.
        adc_sample = 13'h1ABC;
        u_host.frame(16'h00A9, 11, 1'b1, got);
        convert_and_read(2'h0, 13'h1ABC);
        // Reset in mid-conversion returns to shutdown with the strobe high.
        u_host.frame(16'h00A0, 8, 1'b1, got);
        repeat (20) @(negedge ref_clk);
        nrst = 1'b0;
        repeat (20) @(negedge ref_clk);
        `CHECK(strobe, 1'b1)
        `CHECK(dout_o, 1'b0)
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHECK(afe_ctrl.power_mode_select, PM_SHUTDOWN)
        adc_sample = 13'h0042;
        u_host.frame(16'h00A1, 8, 1'b1, got);
        convert_and_read(2'h0, 13'h0042);
        finish_test();
    end

endmodule : testbench

// ### src/stac_pkg.sv
// Purpose: Shared constants and types of the serial temperature ADC control block.
// Assumes: Core clock of 200 MHz; serial link in SPI mode 0.
// Notes: Times are kept in nanoseconds; cycle counts derive from them.
package stac_pkg;

    // ------------------------------------------------------------
    // Core clock and timing.
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_VOLT_NS = 1100000;
    localparam int T_TEMP_NS = 2200000;
    localparam int T_WAKE_NS = 100000;
    localparam int T_SHDN_SPACING_NS = 5000000;
    localparam int VOLT_PERIODS = 64;
    localparam int TEMP_PERIODS = 125;
    // Internal converter clock period in core cycles, rounded down.
    localparam int FCLK_DIV_CYC = T_VOLT_NS / CLK_PERIOD_NS / VOLT_PERIODS;
    // Wake-up delay in core cycles, rounded down.
    localparam int WAKE_CYC = T_WAKE_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    localparam int PER_W = 7;

    // ------------------------------------------------------------
    // Command byte layout.
    // ------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam logic [3:0] CFG_PATTERN = 4'h0;
    localparam logic [2:0] CONV_PATTERN = 3'h2;
    localparam int CFG_PAT_MSB = 6;
    localparam int CFG_PAT_LSB = 3;
    localparam int CONV_PAT_LSB = 4;
    localparam int PM_MSB = 2;
    localparam int PM_LSB = 1;
    localparam int REF_BIT = 0;
    localparam int SEL_MSB = 3;

    // ------------------------------------------------------------
    // Power modes and result frame.
    // ------------------------------------------------------------
    localparam logic [1:0] PM_SHUTDOWN = 2'h0;
    localparam logic [1:0] PM_STANDBY_PLUS = 2'h1;
    localparam logic [1:0] PM_STANDBY = 2'h2;
    localparam logic [1:0] PM_NORMAL = 2'h3;
    localparam logic REF_RESET = 1'h0;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_END = 5'h10;
    localparam int SAMPLE_BITS = 13;
    localparam int TEMP_BITS = 12;

    // Controls handed to the analog front end.
    typedef struct packed {
        logic [1:0] power_mode_select;
        logic ref_internal;
        logic adc_enable;
        logic ref_buffer_enable;
        logic temp_enable;
        logic sample_take;
        logic [3:0] input_channel_select;
    } stac_afe_ctrl_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_CONV} stac_state_t;

endpackage : stac_pkg

// ### src/stac_top.sv
// Purpose: Serial command decoding and conversion sequencing of a temperature ADC.
// Assumes: sclk is the host serial clock, idle low; adc_sample is settled when
//          sample_take pulses.
// Notes: The link logic runs on sclk; sequencing runs on ref_clk.
// Notes on behaviour
// - Input bits are taken on rising serial clock, only while chip select is low.
// - First one bit starts a byte: after select, after config, after 16 result bits.
// - Result leaves on falling serial clock, two bytes, most significant bit first.
// - Temperature frame: two filler bits, twelve-bit value, two zeros.
// - Voltage frame: eleven-bit signed value, three sub bits, two zeros.
// - Power-up selects shutdown until a configuration byte changes it.
// - A conversion byte alone starts a conversion with the kept reference mode.
// - Strobe falls on the last conversion bit falling edge, rises when done.
// - Temperature takes about 2.2 ms, voltage about 1.1 ms.
// - Result MSB appears at strobe rise; each falling edge advances one bit.
// - After sixteen result bits the output shows zeros.
// - Chip select high blocks clocking; running conversions still complete.
// - Reference bit one picks internal, zero picks external, for voltages.
// - Temperature conversions always use the internal reference.
// - Power codes: 00 shutdown, 01 standby plus, 10 standby, 11 normal.
// - Standby turns off converter, clock, buffer, temperature parts; 0.1 ms wake.
// - Standby plus keeps the buffer on, 0.1 ms wake with internal reference.
// - Shutdown turns all off and clears data registers; the frame clears only while the sequencer is idle.
// - Supply channel code equals 64 times supply over reference.
// - Temperature is the difference of two diode conversions, eighth-degree steps.
// - Voltage takes 64 internal clock periods, temperature 125.
// - Channel codes map to single-ended, differential, supply and diode modes.
// - Serial output floats whenever chip select is high.
`timescale 1ns/1ps

module stac_top
#(
    parameter int FCLK_DIV = stac_pkg::FCLK_DIV_CYC,
    parameter int WAKE_EXT = stac_pkg::WAKE_CYC,
    parameter int WAKE_INT = stac_pkg::WAKE_CYC
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_o,
    output logic dout_oe,
    output logic conversion_done_strobe,
    input wire logic [stac_pkg::SAMPLE_BITS-1:0] adc_sample,
    output stac_pkg::stac_afe_ctrl_t afe_ctrl
);
    import stac_pkg::*;

    // ------------------------------------------------------------
    // Channel decoding.
    // ------------------------------------------------------------

    // Diode channels run the two-step temperature sequence.
    function automatic logic chan_is_temp(input logic [3:0] sel);
        chan_is_temp = (sel == 4'h7) || (sel == 4'hC) || (sel == 4'hD);
    endfunction : chan_is_temp

    // Unused codes still sequence, but the result is forced to zero.
    function automatic logic chan_is_used(input logic [3:0] sel);
        chan_is_used = (sel <= 4'h4) || (sel == 4'h6) || (sel == 4'h7)
            || (sel == 4'h8) || (sel == 4'h9) || (sel == 4'hB)
            || (sel == 4'hC) || (sel == 4'hD);
    endfunction : chan_is_used

    // ------------------------------------------------------------
    // Link side: receive on rising sclk.
    // ------------------------------------------------------------
    logic rx_rst_n;
    logic [3:0] bit_cnt_q;
    logic [6:0] shreg_q;
    logic hold_q;
    logic [6:0] body;
    logic is_cfg;
    logic is_conv;
    logic last_bit;
    logic [CMD_BITS-1:0] cmd_byte_q;
    logic cmd_tgl_q;
    logic conv_req_tgl_q;
    logic start_tgl_q;
    logic [4:0] idx_q;
    logic done_tgl_q;
    logic [FRAME_BITS-1:0] frame_q;
    logic readout_done;

    // Raising chip select restarts start-bit hunting at once.
    assign rx_rst_n = nrst & ~cs_n;
    assign body = {shreg_q[5:0], din};
    assign last_bit = (bit_cnt_q == 4'h7);
    assign is_cfg = body[CFG_PAT_MSB:CFG_PAT_LSB] == CFG_PATTERN;
    assign is_conv = body[CFG_PAT_MSB:CONV_PAT_LSB] == CONV_PATTERN;
    // Readout is finished once the launch is seen and all bits have gone.
    assign readout_done = (start_tgl_q == conv_req_tgl_q) && (idx_q == FRAME_END);

    // Bit counter and shift register; zero means hunting for a start bit.
    always_ff @(posedge sclk or negedge rx_rst_n)
    begin
        if (!rx_rst_n)
        begin
            bit_cnt_q <= 4'h0;
            shreg_q <= 7'h00;
        end
        else if (bit_cnt_q == 4'h0)
        begin
            if (din && !hold_q)
            begin
                bit_cnt_q <= 4'h1;
                shreg_q <= 7'h00;
            end
        end
        else if (last_bit)
        begin
            bit_cnt_q <= 4'h0;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shreg_q <= body;
        end
    end

    // After a conversion byte no new start bit is taken until the
    // sixteen result bits have been shifted out or chip select rises.
    always_ff @(posedge sclk or negedge rx_rst_n)
    begin
        if (!rx_rst_n)
        begin
            hold_q <= 1'b0;
        end
        else if (last_bit && is_conv)
        begin
            hold_q <= 1'b1;
        end
        else if (hold_q && readout_done)
        begin
            hold_q <= 1'b0;
        end
    end

    // Command hand-off; these survive chip select so the core can still
    // read the byte after the host releases the link.
    always_ff @(posedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_byte_q <= 8'h00;
            cmd_tgl_q <= 1'b0;
            conv_req_tgl_q <= 1'b0;
        end
        else if (!cs_n && last_bit && (is_cfg || is_conv))
        begin
            cmd_byte_q <= {1'b1, body};
            cmd_tgl_q <= ~cmd_tgl_q;
            if (is_conv)
            begin
                conv_req_tgl_q <= ~conv_req_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Link side: transmit on falling sclk.
    // ------------------------------------------------------------

    // The launch toggle flips on the falling edge of the last conversion
    // bit; the result index restarts there and walks on later edges.
    always_ff @(negedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            start_tgl_q <= 1'b0;
            idx_q <= FRAME_END;
        end
        else if (!cs_n)
        begin
            if (conv_req_tgl_q != start_tgl_q)
            begin
                start_tgl_q <= conv_req_tgl_q;
                idx_q <= 5'h00;
            end
            else if (idx_q != FRAME_END)
            begin
                idx_q <= idx_q + 5'h01;
            end
        end
    end

    // The frame is rewritten only while the strobe is low, or cleared by a
    // shutdown byte while idle; otherwise the host reads a stable word once the strobe has risen.
    always_comb
    begin
        if (idx_q == FRAME_END)
        begin
            dout_o = 1'b0;
        end
        else
        begin
            dout_o = frame_q[4'(15 - idx_q[3:0])];
        end
    end

    assign dout_oe = ~cs_n;
    // Only one toggle moves at a time, so the strobe cannot glitch.
    assign conversion_done_strobe = (start_tgl_q == done_tgl_q);

    // ------------------------------------------------------------
    // Core side: crossings.
    // ------------------------------------------------------------
    logic cmd_s1_q;
    logic cmd_s2_q;
    logic cmd_seen_q;
    logic start_s1_q;
    logic start_s2_q;
    logic start_seen_q;

    // Two-stage synchronisers for the link toggles.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_s1_q <= 1'b0;
            cmd_s2_q <= 1'b0;
            cmd_seen_q <= 1'b0;
            start_s1_q <= 1'b0;
            start_s2_q <= 1'b0;
        end
        else
        begin
            cmd_s1_q <= cmd_tgl_q;
            cmd_s2_q <= cmd_s1_q;
            cmd_seen_q <= cmd_s2_q;
            start_s1_q <= start_tgl_q;
            start_s2_q <= start_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Core side: power and reference setup.
    // ------------------------------------------------------------
    logic [1:0] power_mode_q;
    logic ref_int_q;
    logic cfg_event;
    logic cfg_shutdown;

    assign cfg_event = (cmd_s2_q != cmd_seen_q)
        && (cmd_byte_q[CFG_PAT_MSB:CFG_PAT_LSB] == CFG_PATTERN);
    assign cfg_shutdown = cfg_event && (cmd_byte_q[PM_MSB:PM_LSB] == PM_SHUTDOWN);

    // Mode and reference stay until the next configuration byte.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            power_mode_q <= PM_SHUTDOWN;
            ref_int_q <= REF_RESET;
        end
        else if (cfg_event)
        begin
            power_mode_q <= cmd_byte_q[PM_MSB:PM_LSB];
            ref_int_q <= cmd_byte_q[REF_BIT];
        end
    end

    // ------------------------------------------------------------
    // Core side: conversion sequencer.
    // ------------------------------------------------------------
    stac_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PER_W-1:0] per_q;
    logic [3:0] chan_q;
    logic temp_q;
    logic [SAMPLE_BITS-1:0] first_q;
    logic [CNT_W-1:0] wake_len;
    logic [PER_W-1:0] last_per;
    logic fclk_tick;
    logic per_end;
    logic take_now;
    logic [SAMPLE_BITS-1:0] diff;

    // Wake time depends on what the chosen power mode left running.
    always_comb
    begin
        case (power_mode_q)
            PM_NORMAL: wake_len = '0;
            PM_STANDBY_PLUS: wake_len = CNT_W'(WAKE_EXT);
            PM_STANDBY: wake_len = (ref_int_q || temp_q)
                ? CNT_W'(WAKE_INT) : CNT_W'(WAKE_EXT);
            default: wake_len = CNT_W'(WAKE_INT);
        endcase
    end

    assign last_per = temp_q ? PER_W'(TEMP_PERIODS - 1) : PER_W'(VOLT_PERIODS - 1);
    assign fclk_tick = (cnt_q == CNT_W'(FCLK_DIV - 1));
    assign per_end = (state_q == ST_CONV) && fclk_tick;
    // The first diode step ends three periods early and loads no output.
    assign take_now = per_end && ((per_q == last_per)
        || (temp_q && (per_q == PER_W'(VOLT_PERIODS - 4))));
    assign diff = adc_sample - first_q;

    // Sequencer state; a launch is taken from idle only.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            per_q <= '0;
            start_seen_q <= 1'b0;
            chan_q <= 4'h0;
            temp_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= '0;
                    per_q <= '0;
                    if (start_s2_q != start_seen_q)
                    begin
                        start_seen_q <= start_s2_q;
                        chan_q <= cmd_byte_q[SEL_MSB:0];
                        temp_q <= chan_is_temp(cmd_byte_q[SEL_MSB:0]);
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE:
                begin
                    if (cnt_q >= wake_len)
                    begin
                        cnt_q <= '0;
                        state_q <= ST_CONV;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                ST_CONV:
                begin
                    cnt_q <= fclk_tick ? '0 : cnt_q + CNT_W'(1);
                    if (per_end)
                    begin
                        per_q <= per_q + PER_W'(1);
                        if (per_q == last_per)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Result capture; shutdown clears it only while the sequencer is idle.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            frame_q <= '0;
            first_q <= '0;
        end
        else if (take_now && temp_q && (per_q != last_per))
        begin
            first_q <= adc_sample;
        end
        else if (take_now && !chan_is_used(chan_q))
        begin
            frame_q <= '0;
        end
        else if (take_now && temp_q)
        begin
            frame_q <= {2'b00, diff[TEMP_BITS-1:0], 2'b00};
        end
        else if (take_now)
        begin
            // Supply channel codes come straight from the converter.
            frame_q <= {adc_sample[SAMPLE_BITS-1], adc_sample, 2'b00};
        end
        else if (cfg_shutdown && (state_q == ST_IDLE))
        begin
            frame_q <= '0;
        end
    end

    // Completion raises the strobe once the frame is loaded.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            done_tgl_q <= 1'b0;
        end
        else if (per_end && (per_q == last_per))
        begin
            done_tgl_q <= start_seen_q;
        end
    end

    // ------------------------------------------------------------
    // Core side: analog front-end controls.
    // ------------------------------------------------------------
    logic busy;

    assign busy = (state_q != ST_IDLE);

    // Registered so the front end never sees decode glitches.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            afe_ctrl <= '0;
        end
        else
        begin
            afe_ctrl.power_mode_select <= power_mode_q;
            afe_ctrl.ref_internal <= ref_int_q || (busy && temp_q);
            afe_ctrl.adc_enable <= busy || (power_mode_q == PM_NORMAL);
            afe_ctrl.ref_buffer_enable <= busy || (power_mode_q == PM_NORMAL)
                || ((power_mode_q == PM_STANDBY_PLUS) && ref_int_q);
            afe_ctrl.temp_enable <= busy && temp_q;
            afe_ctrl.sample_take <= take_now;
            afe_ctrl.input_channel_select <= chan_q;
        end
    end

endmodule : stac_top
